// ### core/mcs_pkg.sv
// shared constants and carrier types for the module clock source selector
package mcs_pkg;

  // register byte addresses on the peripheral port
  localparam logic [31:0] MCS_ADDR_OPT1_CFG   = 32'h4004_7004; // option1_config
  localparam logic [31:0] MCS_ADDR_CLK_SELECT = 32'h4004_8004; // module_clock_select
  localparam logic [31:0] MCS_ADDR_TIMER_PIN  = 32'h4004_800C; // timer_pin_select

  // writable bit masks, every other bit is reserved and reads zero
  localparam logic [31:0] MCS_MASK_OPT1_CFG   = 32'h0000_0000;
  localparam logic [31:0] MCS_MASK_CLK_SELECT = 32'h0F00_00F0;
  localparam logic [31:0] MCS_MASK_TIMER_PIN  = 32'h0304_0000;

  // reset values
  localparam logic [31:0] MCS_RST_OPT1_CFG    = 32'h0000_0000;
  localparam logic [31:0] MCS_RST_CLK_SELECT  = 32'h0000_0000;
  localparam logic [31:0] MCS_RST_TIMER_PIN   = 32'h0000_0000;

  // field positions inside module_clock_select
  localparam int MCS_SERIAL_SRC_LSB  = 26; // serial_port_clock_source [27:26]
  localparam int MCS_TIMER_SRC_LSB   = 24; // timer_counter_clock_source [25:24]
  localparam int MCS_CLOCK_OUTPUT_PIN_SEL_LSB  = 5;  // clock_output_select [7:5]
  localparam int MCS_RTC_OUT_SEL_BIT = 4;  // rtc_output_select

  // field positions inside timer_pin_select
  localparam int MCS_TIMER_B_PIN_BIT = 25; // timer_b_ext_clock_pin_select
  localparam int MCS_TIMER_A_PIN_BIT = 24; // timer_a_ext_clock_pin_select
  localparam int MCS_TIMER_B_CAP_BIT = 18; // timer_b_ch0_capture_source

  // module clock source codes
  localparam logic [1:0] MCS_SRC_OFF     = 2'h0;
  localparam logic [1:0] MCS_SRC_FLL     = 2'h1;
  localparam logic [1:0] MCS_SRC_EXT_OSC = 2'h2;
  localparam logic [1:0] MCS_SRC_INT_REF = 2'h3;

  // clock output pin codes, the rest are reserved
  localparam logic [2:0] MCS_CO_BUS      = 3'h2;
  localparam logic [2:0] MCS_CO_LPO      = 3'h3;
  localparam logic [2:0] MCS_CO_INT_REF  = 3'h4;
  localparam logic [2:0] MCS_CO_EXT_OSC  = 3'h6;

  // clock sources arriving from the clock generators
  typedef struct packed {
    logic fll_clock;                // fll output
    logic ext_oscillator_clock;     // external oscillator
    logic internal_reference_clock; // internal reference
    logic low_power_oscillator;     // 1 kHz oscillator
    logic rtc_1hz;                  // real-time clock 1 Hz
  } mcs_clk_src_t;

  // pin and comparator signals feeding the timer selectors
  typedef struct packed {
    logic timer_clock_input_pin0;   // external clock pin 0
    logic timer_clock_input_pin1;   // external clock pin 1
    logic timer_b_channel0_signal;  // timer b channel 0 pin
    logic analog_comparator0;       // comparator 0 output
  } mcs_pin_in_t;

endpackage

// ### core/mcs_sel.sv
// registered selectors used for every routed signal except the clock-output pin
`timescale 1ns/1ps

// four-way selector, code zero gives a static low output
module mcs_sel4 (
  input  wire logic       i_clk,   // system clock
  input  wire logic       i_nrst,  // async reset, active low
  input  wire logic [1:0] i_sel,   // source code
  input  wire logic [3:0] i_src,   // sources, index equals code
  output logic            o_out    // registered result
);
  // code zero indexes a tied-low source so the output parks low
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out <= 1'b0;
    end else begin
      o_out <= i_src[i_sel];
    end
  end
endmodule

// two-way selector
module mcs_sel2 (
  input  wire logic i_clk,   // system clock
  input  wire logic i_nrst,  // async reset, active low
  input  wire logic i_sel,   // 0 picks i_src0, 1 picks i_src1
  input  wire logic i_src0,  // source for code 0
  input  wire logic i_src1,  // source for code 1
  output logic      o_out    // registered result
);
  // registered so every routed output leaves from a flop
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out <= 1'b0;
    end else begin
      o_out <= i_sel ? i_src1 : i_src0;
    end
  end
endmodule

// ### core/mcs_top.sv
// module clock source selector: option registers and signal routing
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps

module mcs_top (
  input  wire logic                 I_SYS_CLK,     // bus clock, 50 MHz
  input  wire logic                 I_NRST,        // system reset, active low
  input  wire logic [31:0]          I_ADDR,        // register byte address
  input  wire logic [31:0]          I_WDATA,       // write data
  input  wire logic                 I_WR,          // write strobe
  input  wire logic                 I_RD,          // read strobe
  input  wire logic                 I_SUPERVISOR,  // access made in supervisor mode
  input  wire mcs_pkg::mcs_clk_src_t I_CLK_SRC,    // clock sources
  input  wire mcs_pkg::mcs_pin_in_t  I_PIN_IN,     // pins and comparator
  output logic [31:0]               O_RDATA,       // read data, cycle after strobe
  output logic                      O_BUS_ERR,     // blocked write, one-cycle pulse
  output logic                      O_SERIAL_CLK,  // serial port tx/rx clock
  output logic                      O_TIMER_CLK,   // timer counter clock
  output logic                      O_CLOCK_OUT,   // clock output pin
  output logic                      O_RTC_CLK_OUT, // rtc clock output pin
  output logic                      O_TIMER_A_EXT, // timer a external clock
  output logic                      O_TIMER_B_EXT, // timer b external clock
  output logic                      O_TIMER_B_CAP  // timer b channel 0 capture input
);
  import mcs_pkg::*;

  // register indices returned by the address decoder
  localparam logic [1:0] IDX_NONE = 2'h0; // unmapped
  localparam logic [1:0] IDX_OPT1 = 2'h1; // option1_config
  localparam logic [1:0] IDX_CSEL = 2'h2; // module_clock_select
  localparam logic [1:0] IDX_TPIN = 2'h3; // timer_pin_select

  logic [31:0] opt1_cfg_r;   // option1_config, all reserved
  logic [31:0] clk_sel_r;    // module_clock_select
  logic [31:0] timer_pin_r;  // timer_pin_select
  logic [1:0]  wr_idx;       // decoded write target
  logic [1:0]  rd_idx;       // decoded read target
  logic        wr_ok;        // write allowed this cycle
  logic        wr_block;     // user-mode write to a mapped register
  logic [31:0] rdata_nxt;    // read data before the output flop
  logic        bus_clk_r;    // bus clock image for the clock-output pin
  logic        clk_out_nxt;  // clock-output pin before its flop
  logic        co_reserved;  // a reserved clock-output code is set

  // decode used by both the write and the read path
  function automatic logic [1:0] reg_index(input logic [31:0] addr);
    if (addr == MCS_ADDR_OPT1_CFG) begin
      return IDX_OPT1;
    end else if (addr == MCS_ADDR_CLK_SELECT) begin
      return IDX_CSEL;
    end else if (addr == MCS_ADDR_TIMER_PIN) begin
      return IDX_TPIN;
    end else begin
      return IDX_NONE;
    end
  endfunction

  assign wr_idx   = reg_index(I_ADDR);
  assign rd_idx   = wr_idx;
  // only supervisor accesses may change state
  assign wr_ok    = I_WR && I_SUPERVISOR;
  assign wr_block = I_WR && !I_SUPERVISOR && (wr_idx != IDX_NONE);

  // option1_config: only the system reset touches it; very-low-leakage
  // stop exit has no path here, so it keeps its value across that exit
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      opt1_cfg_r <= MCS_RST_OPT1_CFG;
    end else if (wr_ok && wr_idx == IDX_OPT1) begin
      opt1_cfg_r <= I_WDATA & MCS_MASK_OPT1_CFG;
    end
  end

  // module_clock_select: reserved bits are masked away on write
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      clk_sel_r <= MCS_RST_CLK_SELECT;
    end else if (wr_ok && wr_idx == IDX_CSEL) begin
      clk_sel_r <= I_WDATA & MCS_MASK_CLK_SELECT;
    end
  end

  // timer_pin_select: capture-source bit is not policed here, software
  // owns keeping it clear when timer b is not capturing
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      timer_pin_r <= MCS_RST_TIMER_PIN;
    end else if (wr_ok && wr_idx == IDX_TPIN) begin
      timer_pin_r <= I_WDATA & MCS_MASK_TIMER_PIN;
    end
  end

  // read mux; unmapped addresses and idle cycles give zero
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (I_RD) begin
      unique case (rd_idx)
        IDX_OPT1: rdata_nxt = opt1_cfg_r;
        IDX_CSEL: rdata_nxt = clk_sel_r;
        IDX_TPIN: rdata_nxt = timer_pin_r;
        IDX_NONE: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RDATA <= 32'h0000_0000;
    end else begin
      O_RDATA <= rdata_nxt;
    end
  end

  // bus error pulse one cycle after a blocked write
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BUS_ERR <= 1'b0;
    end else begin
      O_BUS_ERR <= wr_block;
    end
  end

  // serial port clock; index 0 is tied low so code 00 gates it off
  mcs_sel4 u_serial_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (clk_sel_r[MCS_SERIAL_SRC_LSB +: 2]),
    .i_src  ({I_CLK_SRC.internal_reference_clock,
              I_CLK_SRC.ext_oscillator_clock,
              I_CLK_SRC.fll_clock, 1'b0}),
    .o_out  (O_SERIAL_CLK)
  );

  // timer counter clock, same encoding as the serial port
  mcs_sel4 u_timer_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (clk_sel_r[MCS_TIMER_SRC_LSB +: 2]),
    .i_src  ({I_CLK_SRC.internal_reference_clock,
              I_CLK_SRC.ext_oscillator_clock,
              I_CLK_SRC.fll_clock, 1'b0}),
    .o_out  (O_TIMER_CLK)
  );

  // the bus clock cannot be sampled by itself, so the pin shows a
  // half-rate image of it; a trade of frequency for a clean flop output
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      bus_clk_r <= 1'b0;
    end else begin
      bus_clk_r <= !bus_clk_r;
    end
  end

  // clock-output pin source; reserved codes park the pin low
  always_comb begin
    co_reserved = 1'b0;
    case (clk_sel_r[MCS_CLOCK_OUTPUT_PIN_SEL_LSB +: 3])
      MCS_CO_BUS:     clk_out_nxt = bus_clk_r;
      MCS_CO_LPO:     clk_out_nxt = I_CLK_SRC.low_power_oscillator;
      MCS_CO_INT_REF: clk_out_nxt = I_CLK_SRC.internal_reference_clock;
      MCS_CO_EXT_OSC: clk_out_nxt = I_CLK_SRC.ext_oscillator_clock;
      default: begin
        clk_out_nxt = 1'b0;
        co_reserved = 1'b1;
      end
    endcase
  end

  // clock-output pin flop
  always_ff @(posedge I_SYS_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_CLOCK_OUT <= 1'b0;
    end else begin
      O_CLOCK_OUT <= clk_out_nxt;
    end
  end

  // rtc clock-output pin: 1 Hz clock or oscillator
  mcs_sel2 u_rtc_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (clk_sel_r[MCS_RTC_OUT_SEL_BIT]),
    .i_src0 (I_CLK_SRC.rtc_1hz),
    .i_src1 (I_CLK_SRC.ext_oscillator_clock),
    .o_out  (O_RTC_CLK_OUT)
  );

  // timer b external clock pin; the pin must also be muxed to its timer
  // function outside this block, or the selected pin carries nothing
  mcs_sel2 u_tmr_b_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (timer_pin_r[MCS_TIMER_B_PIN_BIT]),
    .i_src0 (I_PIN_IN.timer_clock_input_pin0),
    .i_src1 (I_PIN_IN.timer_clock_input_pin1),
    .o_out  (O_TIMER_B_EXT)
  );

  // timer a external clock pin
  mcs_sel2 u_tmr_a_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (timer_pin_r[MCS_TIMER_A_PIN_BIT]),
    .i_src0 (I_PIN_IN.timer_clock_input_pin0),
    .i_src1 (I_PIN_IN.timer_clock_input_pin1),
    .o_out  (O_TIMER_A_EXT)
  );

  // timer b channel 0 capture source
  mcs_sel2 u_cap_sel (
    .i_clk  (I_SYS_CLK),
    .i_nrst (I_NRST),
    .i_sel  (timer_pin_r[MCS_TIMER_B_CAP_BIT]),
    .i_src0 (I_PIN_IN.timer_b_channel0_signal),
    .i_src1 (I_PIN_IN.analog_comparator0),
    .o_out  (O_TIMER_B_CAP)
  );

  // ---- checks on the block's own behaviour ----

  // a user-mode write to a mapped register
  sequence s_user_write;
    I_WR && !I_SUPERVISOR && (reg_index(I_ADDR) != IDX_NONE);
  endsequence

  // a supervisor write to module_clock_select
  sequence s_csel_write;
    I_WR && I_SUPERVISOR && (I_ADDR == MCS_ADDR_CLK_SELECT);
  endsequence

  // a read of timer_pin_select
  sequence s_tpin_read;
    I_RD && (I_ADDR == MCS_ADDR_TIMER_PIN);
  endsequence

  property p_serial_off;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    (clk_sel_r[MCS_SERIAL_SRC_LSB +: 2] == MCS_SRC_OFF) |=> !O_SERIAL_CLK;
  endproperty
  a_serial_off: assert property (p_serial_off)
    else $error("serial clock not gated at code 00");

  property p_serial_fll;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    (clk_sel_r[MCS_SERIAL_SRC_LSB +: 2] == MCS_SRC_FLL)
      |=> (O_SERIAL_CLK == $past(I_CLK_SRC.fll_clock));
  endproperty
  a_serial_fll: assert property (p_serial_fll)
    else $error("serial clock not following fll clock");

  property p_timer_ref;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    (clk_sel_r[MCS_TIMER_SRC_LSB +: 2] == MCS_SRC_INT_REF)
      |=> (O_TIMER_CLK == $past(I_CLK_SRC.internal_reference_clock));
  endproperty
  a_timer_ref: assert property (p_timer_ref)
    else $error("timer clock not following reference clock");

  property p_timer_osc;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    (clk_sel_r[MCS_TIMER_SRC_LSB +: 2] == MCS_SRC_EXT_OSC)
      |=> (O_TIMER_CLK == $past(I_CLK_SRC.ext_oscillator_clock));
  endproperty
  a_timer_osc: assert property (p_timer_osc)
    else $error("timer clock not following oscillator");

  property p_clock_output_pin_lpo;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    (clk_sel_r[MCS_CLOCK_OUTPUT_PIN_SEL_LSB +: 3] == MCS_CO_LPO)
      |=> (O_CLOCK_OUT == $past(I_CLK_SRC.low_power_oscillator));
  endproperty
  a_clock_output_pin_lpo: assert property (p_clock_output_pin_lpo)
    else $error("clock output not following lpo");

  property p_clock_output_pin_rsvd;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    co_reserved [*2] |=> !O_CLOCK_OUT;
  endproperty
  a_clock_output_pin_rsvd: assert property (p_clock_output_pin_rsvd)
    else $error("clock output toggles on reserved code");

  property p_rtc_out;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    I_NRST |=> (O_RTC_CLK_OUT == ($past(clk_sel_r[MCS_RTC_OUT_SEL_BIT]) ?
              $past(I_CLK_SRC.ext_oscillator_clock) : $past(I_CLK_SRC.rtc_1hz)));
  endproperty
  a_rtc_out: assert property (p_rtc_out)
    else $error("rtc output source wrong");

  property p_tmr_b_pin;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    timer_pin_r[MCS_TIMER_B_PIN_BIT]
      |=> (O_TIMER_B_EXT == $past(I_PIN_IN.timer_clock_input_pin1));
  endproperty
  a_tmr_b_pin: assert property (p_tmr_b_pin)
    else $error("timer b clock not from pin 1");

  property p_tmr_a_pin;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    I_NRST && !timer_pin_r[MCS_TIMER_A_PIN_BIT]
      |=> (O_TIMER_A_EXT == $past(I_PIN_IN.timer_clock_input_pin0));
  endproperty
  a_tmr_a_pin: assert property (p_tmr_a_pin)
    else $error("timer a clock not from pin 0");

  property p_cap_cmp;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    timer_pin_r[MCS_TIMER_B_CAP_BIT]
      |=> (O_TIMER_B_CAP == $past(I_PIN_IN.analog_comparator0));
  endproperty
  a_cap_cmp: assert property (p_cap_cmp)
    else $error("capture input not from comparator");

  property p_rsvd_read;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    s_tpin_read |=> ((O_RDATA & ~MCS_MASK_TIMER_PIN) == 32'h0000_0000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read)
    else $error("reserved bits read nonzero");

  property p_csel_store;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    s_csel_write |=> (clk_sel_r == ($past(I_WDATA) & MCS_MASK_CLK_SELECT));
  endproperty
  a_csel_store: assert property (p_csel_store)
    else $error("module clock select write not stored");

  property p_opt1_zero;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    1'b1 |-> (opt1_cfg_r == MCS_RST_OPT1_CFG);
  endproperty
  a_opt1_zero: assert property (p_opt1_zero)
    else $error("option1 config left its reset value");

  property p_user_block;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    s_user_write |=> (O_BUS_ERR && $stable(clk_sel_r) && $stable(timer_pin_r));
  endproperty
  a_user_block: assert property (p_user_block)
    else $error("user write not blocked");

  property p_err_cause;
    @(posedge I_SYS_CLK) disable iff (!I_NRST)
    O_BUS_ERR |-> $past(I_WR && !I_SUPERVISOR);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("bus error without a user write");

endmodule

// ### verif/mcs_tb.sv
// self-checking testbench for the module clock source selector
`timescale 1ns/1ps

module testbench;
  import mcs_pkg::*;

  logic         I_SYS_CLK;     // 50 MHz bench clock
  logic         I_NRST;        // system reset, active low
  logic [31:0]  I_ADDR;        // register address
  logic [31:0]  I_WDATA;       // write data
  logic         I_WR;          // write strobe
  logic         I_RD;          // read strobe
  logic         I_SUPERVISOR;  // access privilege
  mcs_clk_src_t I_CLK_SRC;     // random clock source levels
  mcs_pin_in_t  I_PIN_IN;      // random pin levels
  logic [31:0]  O_RDATA;       // read data
  logic         O_BUS_ERR;     // blocked write pulse
  logic         O_SERIAL_CLK;  // routed serial clock
  logic         O_TIMER_CLK;   // routed timer clock
  logic         O_CLOCK_OUT;   // clock output pin
  logic         O_RTC_CLK_OUT; // rtc output pin
  logic         O_TIMER_A_EXT; // timer a external clock
  logic         O_TIMER_B_EXT; // timer b external clock
  logic         O_TIMER_B_CAP; // timer b capture input
  int           n_mismatch;    // failed comparisons
  int           comparisons;   // comparisons made
  int           seed;          // fixed random seed
  int           co_run;        // edges in a row with bus clock selected
  logic [31:0]  clk_m;         // model of module_clock_select
  logic [31:0]  pin_m;         // model of timer_pin_select
  logic [31:0]  wd;            // scratch write data
  logic [31:0]  r;             // scratch random word
  logic [31:0]  e_rd;          // expected read data
  logic [2:0]   co_c;          // clock output code in force
  logic         co_prev;       // clock output before the edge
  logic         e_err;         // expected error pulse
  logic         e_ser;         // expected routed levels follow
  logic         e_tmr;
  logic         e_co;
  logic         e_rtc;
  logic         e_ta;
  logic         e_tb;
  logic         e_cap;
  logic [31:0]  addrs [4];     // three mapped places and one unmapped

  mcs_top i_mcs_top (
    .I_SYS_CLK(I_SYS_CLK), .I_NRST(I_NRST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
    .I_WR(I_WR), .I_RD(I_RD), .I_SUPERVISOR(I_SUPERVISOR), .I_CLK_SRC(I_CLK_SRC),
    .I_PIN_IN(I_PIN_IN), .O_RDATA(O_RDATA), .O_BUS_ERR(O_BUS_ERR),
    .O_SERIAL_CLK(O_SERIAL_CLK), .O_TIMER_CLK(O_TIMER_CLK), .O_CLOCK_OUT(O_CLOCK_OUT),
    .O_RTC_CLK_OUT(O_RTC_CLK_OUT), .O_TIMER_A_EXT(O_TIMER_A_EXT),
    .O_TIMER_B_EXT(O_TIMER_B_EXT), .O_TIMER_B_CAP(O_TIMER_B_CAP)
  );

  // clock generator, 20 ns period
  initial I_SYS_CLK = 1'b0;
  always #10 I_SYS_CLK = ~I_SYS_CLK;

  // model value seen by a read; option1_config and holes read zero
  function automatic logic [31:0] reg_of(input logic [31:0] a);
    if (a === MCS_ADDR_CLK_SELECT) return clk_m;
    if (a === MCS_ADDR_TIMER_PIN) return pin_m;
    return 32'h0000_0000;
  endfunction

  // only the three option registers raise a bus error
  function automatic logic mapped(input logic [31:0] a);
    return (a === MCS_ADDR_OPT1_CFG) || (a === MCS_ADDR_CLK_SELECT) || (a === MCS_ADDR_TIMER_PIN);
  endfunction

  // module clock source, code zero gates the clock off
  function automatic logic pick4(input logic [1:0] c, input mcs_clk_src_t s);
    case (c)
      MCS_SRC_FLL:     return s.fll_clock;
      MCS_SRC_EXT_OSC: return s.ext_oscillator_clock;
      MCS_SRC_INT_REF: return s.internal_reference_clock;
      default:         return 1'b0;
    endcase
  endfunction

  // clock output pin; reserved codes stay low, bus clock is checked apart
  function automatic logic pick_co(input logic [2:0] c, input mcs_clk_src_t s);
    case (c)
      MCS_CO_LPO:     return s.low_power_oscillator;
      MCS_CO_INT_REF: return s.internal_reference_clock;
      MCS_CO_EXT_OSC: return s.ext_oscillator_clock;
      default:        return 1'b0;
    endcase
  endfunction

  task automatic chk_bit(input string name, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic chk_word(input string name, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic give_verdict();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one bus cycle; strobes drop only when the next call or idle replaces them
  task automatic bus(input logic wr, input logic rd, input logic [31:0] a,
                     input logic [31:0] d, input logic sup);
    I_WR <= wr;
    I_RD <= rd;
    I_ADDR <= a;
    I_WDATA <= d;
    I_SUPERVISOR <= sup;
    @(posedge I_SYS_CLK);
  endtask

  // fresh source and pin levels every cycle so a stale route shows up
  always @(posedge I_SYS_CLK) begin
    {I_CLK_SRC, I_PIN_IN} <= 9'($random(seed));
  end

  // reference model: predict from pre-edge values, compare once the edge settled
  always @(posedge I_SYS_CLK) begin
    if (I_NRST !== 1'b1) begin
      clk_m = 32'h0000_0000;
      pin_m = 32'h0000_0000;
      co_run = 0;
    end else begin
      co_c = clk_m[MCS_CLOCK_OUTPUT_PIN_SEL_LSB +: 3];
      e_rd = I_RD ? reg_of(I_ADDR) : 32'h0000_0000;
      e_err = I_WR && !I_SUPERVISOR && mapped(I_ADDR);
      e_ser = pick4(clk_m[MCS_SERIAL_SRC_LSB +: 2], I_CLK_SRC);
      e_tmr = pick4(clk_m[MCS_TIMER_SRC_LSB +: 2], I_CLK_SRC);
      e_co = pick_co(co_c, I_CLK_SRC);
      e_rtc = clk_m[MCS_RTC_OUT_SEL_BIT] ? I_CLK_SRC.ext_oscillator_clock : I_CLK_SRC.rtc_1hz;
      e_ta = pin_m[MCS_TIMER_A_PIN_BIT] ? I_PIN_IN.timer_clock_input_pin1
                                        : I_PIN_IN.timer_clock_input_pin0;
      e_tb = pin_m[MCS_TIMER_B_PIN_BIT] ? I_PIN_IN.timer_clock_input_pin1
                                        : I_PIN_IN.timer_clock_input_pin0;
      e_cap = pin_m[MCS_TIMER_B_CAP_BIT] ? I_PIN_IN.analog_comparator0
                                         : I_PIN_IN.timer_b_channel0_signal;
      co_run = (co_c === MCS_CO_BUS) ? co_run + 1 : 0;
      co_prev = O_CLOCK_OUT;
      // privileged writes land, reserved bits are dropped
      if (I_WR && I_SUPERVISOR && I_ADDR === MCS_ADDR_CLK_SELECT) clk_m = I_WDATA & MCS_MASK_CLK_SELECT;
      if (I_WR && I_SUPERVISOR && I_ADDR === MCS_ADDR_TIMER_PIN) pin_m = I_WDATA & MCS_MASK_TIMER_PIN;
      #1;
      // a reset arriving at this edge clears outputs, nothing to compare
      if (I_NRST === 1'b1) begin
        chk_word("read data", e_rd, O_RDATA);
        chk_bit("bus error", e_err, O_BUS_ERR);
        chk_bit("serial clock", e_ser, O_SERIAL_CLK);
        chk_bit("timer clock", e_tmr, O_TIMER_CLK);
        if (co_c !== MCS_CO_BUS) chk_bit("clock out", e_co, O_CLOCK_OUT);
        if (co_run >= 2) chk_bit("clock out toggle", ~co_prev, O_CLOCK_OUT);
        chk_bit("rtc clock out", e_rtc, O_RTC_CLK_OUT);
        chk_bit("timer a ext", e_ta, O_TIMER_A_EXT);
        chk_bit("timer b ext", e_tb, O_TIMER_B_EXT);
        chk_bit("timer b capture", e_cap, O_TIMER_B_CAP);
      end
    end
  end

  // watchdog, far beyond the roughly 660 cycles the sequence needs
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial begin
    seed = 13;
    n_mismatch = 0;
    comparisons = 0;
    addrs = '{MCS_ADDR_OPT1_CFG, MCS_ADDR_CLK_SELECT, MCS_ADDR_TIMER_PIN, 32'h4004_8010};
    {I_NRST, I_WR, I_RD, I_SUPERVISOR} = 4'h0;
    I_ADDR = 32'h0000_0000;
    I_WDATA = 32'h0000_0000;
    {I_CLK_SRC, I_PIN_IN} = 9'h000;
    repeat (2) @(posedge I_SYS_CLK);
    I_NRST <= 1'b1;
    // reset values, back-to-back reads including an unmapped hole
    for (int k = 0; k < 4; k++) bus(1'b0, 1'b1, addrs[k], 32'h0000_0000, 1'b1);
    // every selector code, with noise in the reserved bits
    for (int c = 0; c < 8; c++) begin
      wd = $random(seed);
      wd[7:5] = 3'(c);
      wd[27:26] = 2'(c);
      wd[25:24] = ~2'(c);
      bus(1'b1, 1'b0, MCS_ADDR_CLK_SELECT, wd, 1'b1);
      wd = $random(seed);
      wd[25:24] = 2'(c);
      wd[18] = c[2];
      bus(1'b1, 1'b0, MCS_ADDR_TIMER_PIN, wd, 1'b1);
      repeat (12) bus(1'b0, 1'b0, MCS_ADDR_OPT1_CFG, 32'h0000_0000, 1'b0);
      bus(1'b0, 1'b1, MCS_ADDR_CLK_SELECT, 32'h0000_0000, 1'b1);
      bus(1'b0, 1'b1, MCS_ADDR_TIMER_PIN, 32'h0000_0000, 1'b0);
    end
    // user-mode writes refused, then read back at once
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 1'b0, addrs[k], 32'hFFFF_FFFF, 1'b0);
      bus(1'b0, 1'b1, addrs[k], 32'h0000_0000, 1'b0);
    end
    // random traffic: privileged and user writes, reads, idle cycles
    repeat (500) begin
      r = $random(seed);
      wd = $random(seed);
      case (r[2:0])
        3'h0, 3'h1, 3'h2: bus(1'b1, 1'b0, addrs[r[4:3]], wd, 1'b1);
        3'h3:             bus(1'b1, 1'b0, addrs[r[4:3]], wd, 1'b0);
        3'h4, 3'h5:       bus(1'b0, 1'b1, addrs[r[4:3]], wd, r[5]);
        default:          bus(1'b0, 1'b0, addrs[r[4:3]], wd, 1'b0);
      endcase
    end
    // a second reset in mid-run must clear everything again
    bus(1'b1, 1'b0, MCS_ADDR_CLK_SELECT, 32'hFFFF_FFFF, 1'b1);
    bus(1'b1, 1'b0, MCS_ADDR_TIMER_PIN, 32'hFFFF_FFFF, 1'b1);
    bus(1'b0, 1'b0, MCS_ADDR_OPT1_CFG, 32'h0000_0000, 1'b0);
    I_NRST <= 1'b0;
    repeat (2) @(posedge I_SYS_CLK);
    I_NRST <= 1'b1;
    for (int k = 0; k < 4; k++) bus(1'b0, 1'b1, addrs[k], 32'h0000_0000, 1'b1);
    // software leaves the capture source cleared once capture use ends
    bus(1'b1, 1'b0, MCS_ADDR_TIMER_PIN, 32'h0000_0000, 1'b1);
    repeat (4) bus(1'b0, 1'b0, MCS_ADDR_OPT1_CFG, 32'h0000_0000, 1'b0);
    give_verdict();
  end
endmodule
